/* core/sld_core.sv */
// Segment LCD driver control: APB register file, clock select, prescaler and common scan.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Control bit 7 enables the driver; zero disables it.
// - Sleep-disable bit set stops the driver during sleep; clear keeps it running.
// - Pixel write without write allow sets the error flag; software only clears it.
// - Clock source 00 system/256, 01 crystal oscillator, 1x low-frequency oscillator.
// - Commons field picks static, two, three or four commons.
// - Up to four commons and 24 segments; small variant has 16 segments.
// - Small variant loses segment 15 when four commons are selected.
// - Waveform bit one changes phase per frame, zero within each common.
// - Read-only active bit shows whether the driver runs.
// - Read-only write-allow bit shows whether pixel writes are accepted.
// - Prescale field divides driver clock by field value plus one.
// - Reference enable connects internal reference to contrast control.
// - Reference source zero uses supply, one uses fixed reference output.
// - Ladder-idle bit turns fixed-reference buffer off in ladder mode B.
// - Bits 3 to 1 connect the three bias pins.
// - Pixel bit one is dark; register 3*common+group holds eight segments.
// - Segment-enable registers cover segments in groups of eight.
// - Small variant has two enable and eight pixel registers, large three and twelve.
// - Unimplemented control and reference bits read as zero.
// - Segment-enable one gives segment drive, zero leaves general I/O.
// - Reference ladder is off whenever the driver is inactive.
// - The four-bit prescale counter is hidden from software.
module sld_core
   import sld_pkg::*;
#(
   parameter int NUM_SEG = 24
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 sleep_in,
   input  wire logic                 crystal_timer_oscillator,
   input  wire logic                 low_frequency_internal_oscillator,
   input  wire logic                 ladder_mode_b,
   output logic                      active_status,
   output logic [1:0]                common_index,
   output logic                      drive_phase,
   output logic                      waveform_type,
   output sld_bias_t                 bias_level,
   output logic [23:0]               segment_enable,
   output logic [23:0]               pixel_row,
   output sld_ref_t                  ref_ctl
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   localparam int NUM_GRP = NUM_SEG / 8;

   // A pixel or enable group exists only if the variant has that many segments.
   function automatic logic grp_ok(input logic [7:0] off, input logic [7:0] base);
      logic [3:0] idx;
      idx = 4'(((off - base) >> 2) % 8'd3);
      return idx < 4'(NUM_GRP);
   endfunction

   function automatic logic pix_hit(input logic [7:0] a);
      return a >= SLD_OFF_PIXEL0 && a < 8'(SLD_OFF_PIXEL0 + 4 * SLD_NUM_PIXEL) && a[1:0] == 2'b00;
   endfunction

   function automatic logic seg_hit(input logic [7:0] a);
      return a >= SLD_OFF_SEGEN0 && a < 8'(SLD_OFF_SEGEN0 + 4 * SLD_NUM_SEGEN) && a[1:0] == 2'b00;
   endfunction

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [7:0]  control_r;
   logic [7:0]  phase_r;
   logic [7:0]  refctl_r;
   logic [7:0]  segen_r [SLD_NUM_SEGEN];
   logic [7:0]  pixel_r [SLD_NUM_PIXEL];
   logic        write_allow_r;
   logic        active_r;
   logic [7:0]  prdata_r;
   logic        pslverr_r;

   logic        wr_en;
   logic        setup;
   logic        mapped;
   logic [3:0]  pix_idx;
   logic [1:0]  seg_idx;
   logic        pix_wr;

   assign setup   = psel && !penable;
   assign wr_en   = psel && penable && pwrite;
   assign pix_idx = 4'((paddr - SLD_OFF_PIXEL0) >> 2);
   assign seg_idx = 2'((paddr - SLD_OFF_SEGEN0) >> 2);
   assign pix_wr  = wr_en && pix_hit(paddr) && grp_ok(paddr, SLD_OFF_PIXEL0);
   assign mapped  = paddr == SLD_OFF_CONTROL || paddr == SLD_OFF_PHASE || paddr == SLD_OFF_REFCTL
                    || (seg_hit(paddr) && 2'(seg_idx) < 2'(NUM_GRP))
                    || (pix_hit(paddr) && grp_ok(paddr, SLD_OFF_PIXEL0));

   // ****************************************************************
   // Control register with the sticky error flag
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_r <= SLD_RST_CONTROL;
      end else begin
         if (wr_en && paddr == SLD_OFF_CONTROL) begin
            control_r <= (pwdata[7:0] & SLD_MASK_CONTROL)
                         | {2'b00, control_r[SLD_CTL_WRITE_ERROR_FLAG] & pwdata[SLD_CTL_WRITE_ERROR_FLAG], 5'b0_0000};
         end
         if (pix_wr && !write_allow_r) begin
            control_r[SLD_CTL_WRITE_ERROR_FLAG] <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r  <= SLD_RST_PHASE;
         refctl_r <= SLD_RST_REFCTL;
      end else begin
         if (wr_en && paddr == SLD_OFF_PHASE) begin
            phase_r <= pwdata[7:0] & SLD_MASK_PHASE;
         end
         if (wr_en && paddr == SLD_OFF_REFCTL) begin
            refctl_r <= pwdata[7:0] & SLD_MASK_REFCTL;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < SLD_NUM_SEGEN; i++) begin
            segen_r[i] <= 8'h00;
         end
         for (int i = 0; i < SLD_NUM_PIXEL; i++) begin
            pixel_r[i] <= 8'h00;
         end
      end else begin
         if (wr_en && seg_hit(paddr) && 2'(seg_idx) < 2'(NUM_GRP)) begin
            segen_r[seg_idx] <= pwdata[7:0];
         end
         // A refused write is dropped, so the pixel register keeps its old value.
         if (pix_wr && write_allow_r) begin
            pixel_r[pix_idx] <= pwdata[7:0];
         end
      end
   end

   // ****************************************************************
   // APB read path, answered with no wait states
   // ****************************************************************
   logic [7:0] rd_val;
   always_comb begin
      rd_val = 8'h00;
      if (paddr == SLD_OFF_CONTROL) begin
         rd_val = control_r;
      end else if (paddr == SLD_OFF_PHASE) begin
         rd_val = {phase_r[7:6], active_r, write_allow_r, phase_r[3:0]};
      end else if (paddr == SLD_OFF_REFCTL) begin
         rd_val = refctl_r;
      end else if (mapped && seg_hit(paddr)) begin
         rd_val = segen_r[seg_idx];
      end else if (mapped && pix_hit(paddr)) begin
         rd_val = pixel_r[pix_idx];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= 8'h00;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         prdata_r  <= rd_val;
         pslverr_r <= !mapped;
      end
   end

   assign prdata  = {24'h00_0000, prdata_r};
   assign pready  = 1'b1;
   assign pslverr = pslverr_r && psel && penable;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [2:0] sleep_s;
   logic [2:0] xtal_s;
   logic [2:0] lfo_s;
   logic [1:0] ladb_s;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_s <= 3'b000;
         xtal_s  <= 3'b000;
         lfo_s   <= 3'b000;
         ladb_s  <= 2'b00;
      end else begin
         sleep_s <= {sleep_s[1:0], sleep_in};
         xtal_s  <= {xtal_s[1:0], crystal_timer_oscillator};
         lfo_s   <= {lfo_s[1:0], low_frequency_internal_oscillator};
         ladb_s  <= {ladb_s[0], ladder_mode_b};
      end
   end

   // ****************************************************************
   // Driver clock source and prescaler
   // ****************************************************************
   logic [7:0] sysdiv_r;
   logic       src_tick;
   logic [3:0] pre_cnt_r;
   logic       step;
   logic       active_nxt;

   // Sleep state is read from the second stage, so stop takes effect three edges after the pin.
   assign active_nxt = control_r[SLD_CTL_ENABLE]
                       && !(sleep_s[1] && control_r[SLD_CTL_SLEEPDIS]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_r <= 1'b0;
      end else begin
         active_r <= active_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sysdiv_r <= 8'h00;
      end else begin
         sysdiv_r <= sysdiv_r + 8'h01;
      end
   end

   always_comb begin
      case (control_r[3:2])
         2'b00:   src_tick = sysdiv_r == SLD_SYSDIV_LAST;
         2'b01:   src_tick = xtal_s[1] && !xtal_s[2];
         default: src_tick = lfo_s[1] && !lfo_s[2];
      endcase
   end

   // The slow oscillators are sampled on pclk, so they must run well below half the pclk rate.
   assign step = active_r && src_tick && pre_cnt_r == phase_r[3:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_r <= 4'h0;
      end else if (!active_r) begin
         pre_cnt_r <= 4'h0;
      end else if (src_tick) begin
         pre_cnt_r <= step ? 4'h0 : pre_cnt_r + 4'h1;
      end
   end

   // Writes are refused in the cycle after each prescaler match on src_tick while active_nxt is set, whether or not the common changes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_allow_r <= 1'b1;
      end else begin
         write_allow_r <= !(active_nxt && src_tick && pre_cnt_r == phase_r[3:0]);
      end
   end

   // ****************************************************************
   // Common scan and row latch
   // ****************************************************************
   logic [1:0]  com_r;
   logic        phase_bit_r;
   logic [23:0] row_r;
   logic [1:0]  mux;
   logic        last_com;

   assign mux      = control_r[1:0];
   assign last_com = com_r >= mux;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         com_r       <= 2'b00;
         phase_bit_r <= 1'b0;
      end else if (!active_r) begin
         com_r       <= 2'b00;
         phase_bit_r <= 1'b0;
      end else if (step) begin
         if (phase_r[SLD_PS_WFT]) begin
            com_r <= last_com ? 2'b00 : com_r + 2'b01;
            if (last_com) begin
               phase_bit_r <= !phase_bit_r;
            end
         end else begin
            phase_bit_r <= !phase_bit_r;
            if (phase_bit_r) begin
               com_r <= last_com ? 2'b00 : com_r + 2'b01;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         row_r <= 24'h00_0000;
      end else if (!active_r) begin
         row_r <= 24'h00_0000;
      end else begin
         for (int g = 0; g < 3; g++) begin
            row_r[g*8 +: 8] <= (g < NUM_GRP) ? pixel_r[3 * com_r + g] : 8'h00;
         end
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   logic [23:0] seg_vec;
   always_comb begin
      seg_vec = 24'h00_0000;
      for (int g = 0; g < NUM_GRP; g++) begin
         seg_vec[g*8 +: 8] = segen_r[g];
      end
      if (NUM_SEG == 16 && mux == 2'b11) begin
         seg_vec[15] = 1'b0;
      end
   end

   sld_bias_t bias_c;
   always_comb begin
      case (mux)
         2'b00:        bias_c = SLD_BIAS_STATIC;
         2'b01, 2'b10: bias_c = phase_r[SLD_PS_BIAS] ? SLD_BIAS_HALF : SLD_BIAS_THIRD;
         default:      bias_c = SLD_BIAS_THIRD;
      endcase
   end

   assign active_status  = active_r;
   assign common_index   = com_r;
   assign drive_phase    = phase_bit_r;
   assign waveform_type  = phase_r[SLD_PS_WFT];
   assign bias_level     = bias_c;
   assign segment_enable = seg_vec;
   assign pixel_row      = row_r;

   assign ref_ctl.ref_enable       = refctl_r[SLD_REF_IRE];
   assign ref_ctl.ref_from_fvr     = refctl_r[SLD_REF_IRE] && refctl_r[SLD_REF_IRS];
   assign ref_ctl.fvr_buffer_on    = refctl_r[SLD_REF_IRE]
                                     && !(refctl_r[SLD_REF_IRI] && ladb_s[1]);
   assign ref_ctl.ladder_on        = active_r;
   assign ref_ctl.bias_pin_connect = refctl_r[SLD_REF_PIN3:SLD_REF_PIN1];

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_enable_off: assert property (!control_r[SLD_CTL_ENABLE] |=> !active_status)
      else $error("driver active while disabled");
   chk_sleep_stop: assert property (sleep_s[1] && control_r[SLD_CTL_SLEEPDIS] |=> !active_status)
      else $error("driver ran in sleep with sleep disable set");
   chk_write_error_flag_set: assert property (pix_wr && !write_allow_r |=> control_r[SLD_CTL_WRITE_ERROR_FLAG])
      else $error("refused pixel write did not flag error");
   chk_write_error_flag_hold: assert property (control_r[SLD_CTL_WRITE_ERROR_FLAG] && !(wr_en && paddr == SLD_OFF_CONTROL)
                                   |=> control_r[SLD_CTL_WRITE_ERROR_FLAG])
      else $error("error flag dropped without a write");
   chk_pixel_keep: assert property (pix_wr && !write_allow_r
                                    |=> pixel_r[$past(pix_idx)] == $past(pixel_r[pix_idx]))
      else $error("refused pixel write changed data");
   chk_segment_output_15_mask: assert property (NUM_SEG == 16 && mux == 2'b11 |-> !segment_enable[15])
      else $error("segment 15 enabled with four commons");
   chk_ladder_off: assert property (!active_status |-> !ref_ctl.ladder_on)
      else $error("ladder on while inactive");
   chk_prescale_div: assert property (step |=> !step [*1] ##0 (pre_cnt_r == 4'h0))
      else $error("prescale counter not restarted after step");
   chk_com_range: assert property (active_status |-> common_index <= mux)
      else $error("common index beyond selected count");
   chk_slverr: assert property (psel && penable && !pslverr |-> $past(mapped))
      else $error("unmapped address answered without error");

   cov_refused: cover property (pix_wr && !write_allow_r);
   cov_frame: cover property (step && last_com && active_status);
   cov_write_error_flag_clear: cover property (control_r[SLD_CTL_WRITE_ERROR_FLAG] ##1 !control_r[SLD_CTL_WRITE_ERROR_FLAG]);

endmodule

`default_nettype wire

/* core/sld_pkg.sv */
// Package with register map, field layout and shared types of the segment LCD driver control block.
package sld_pkg;

   // ****************************************************************
   // Register word offsets
   // ****************************************************************
   localparam logic [7:0] SLD_OFF_CONTROL  = 8'h00;
   localparam logic [7:0] SLD_OFF_PHASE    = 8'h04;
   localparam logic [7:0] SLD_OFF_REFCTL   = 8'h08;
   localparam logic [7:0] SLD_OFF_SEGEN0   = 8'h10;
   localparam logic [7:0] SLD_OFF_PIXEL0   = 8'h20;
   localparam int         SLD_NUM_SEGEN    = 3;
   localparam int         SLD_NUM_PIXEL    = 12;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int SLD_CTL_ENABLE   = 7;
   localparam int SLD_CTL_SLEEPDIS = 6;
   localparam int SLD_CTL_WRITE_ERROR_FLAG     = 5;
   localparam int SLD_CTL_CS_LO    = 2;
   localparam int SLD_CTL_MUX_LO   = 0;
   localparam int SLD_PS_WFT       = 7;
   localparam int SLD_PS_BIAS      = 6;
   localparam int SLD_PS_ACTIVE    = 5;
   localparam int SLD_PS_WA        = 4;
   localparam int SLD_PS_LP_LO     = 0;
   localparam int SLD_REF_IRE      = 7;
   localparam int SLD_REF_IRS      = 6;
   localparam int SLD_REF_IRI      = 5;
   localparam int SLD_REF_PIN3     = 3;
   localparam int SLD_REF_PIN1     = 1;

   // ****************************************************************
   // Reset values, write masks and timing
   // ****************************************************************
   localparam logic [7:0] SLD_RST_CONTROL  = 8'h03;
   localparam logic [7:0] SLD_RST_PHASE    = 8'h03;
   localparam logic [7:0] SLD_RST_REFCTL   = 8'h00;
   localparam logic [7:0] SLD_MASK_CONTROL = 8'hCF;
   localparam logic [7:0] SLD_MASK_PHASE   = 8'hCF;
   localparam logic [7:0] SLD_MASK_REFCTL  = 8'hEE;
   localparam logic [7:0] SLD_SYSDIV_LAST  = 8'hFF;

   typedef enum logic [1:0] {
      SLD_BIAS_STATIC = 2'b00,
      SLD_BIAS_HALF   = 2'b01,
      SLD_BIAS_THIRD  = 2'b10
   } sld_bias_t;

   typedef struct packed {
      logic ref_enable;
      logic ref_from_fvr;
      logic fvr_buffer_on;
      logic ladder_on;
      logic [3:1] bias_pin_connect;
   } sld_ref_t;

endpackage

/* dv/sld_panel_model.sv */
// Behavioural panel and slow clock sources seen at the far side of the driver.
`timescale 1ns/100ps
`default_nettype none
module sld_panel_model (
   input  wire logic        pclk,
   input  wire logic [1:0]  common_index,
   input  wire logic [23:0] pixel_row,
   output logic             xtal_clk,
   output logic             lf_clk,
   output logic             mode_b
);
   // ************************************************************
   // Slow clocks, both unrelated in phase to the bus clock.
   // ************************************************************
   logic [23:0] glass [4];
   initial begin
      xtal_clk = 1'b0;
      #13;
      forever #350 xtal_clk = ~xtal_clk;
   end
   initial begin
      lf_clk = 1'b0;
      #7;
      forever #250 lf_clk = ~lf_clk;
   end
   // The ladder flips power mode each slow tick, so the buffer logic never sees a frozen level.
   initial mode_b = 1'b0;
   always @(posedge lf_clk) mode_b <= ~mode_b;
   // Four commons by 24 segments of glass hold the last row driven on each common.
   always @(posedge pclk) glass[common_index] <= pixel_row;
endmodule
`default_nettype wire

/* dv/tb_segment_lcd_driver_control.sv */
// Self-checking testbench of the segment LCD driver control block.
`timescale 1ns/100ps
`default_nettype none
module tb_segment_lcd_driver_control;
   import sld_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, sleep_in, pready, pslverr, active_status;
   logic        drive_phase, waveform_type, xtal, lfo, mode_b, er;
   logic [7:0]  paddr, v;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [1:0]  common_index;
   logic [23:0] segment_enable, pixel_row, seg, seg16;
   logic [7:0]  pix [12];
   sld_bias_t   bias_level;
   sld_ref_t    ref_ctl;
   int          n_fail, total_checks, n, p, mx;
   int          per [4] = '{256, 14, 10, 10};
   sld_core #(.NUM_SEG(24)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleep_in(sleep_in), .crystal_timer_oscillator(xtal), .low_frequency_internal_oscillator(lfo),
      .ladder_mode_b(mode_b), .active_status(active_status), .common_index(common_index),
      .drive_phase(drive_phase), .waveform_type(waveform_type), .bias_level(bias_level),
      .segment_enable(segment_enable), .pixel_row(pixel_row), .ref_ctl(ref_ctl));
   sld_panel_model panel_u (.pclk(pclk), .common_index(common_index), .pixel_row(pixel_row),
      .xtal_clk(xtal), .lf_clk(lfo), .mode_b(mode_b));
   // The small variant shares the bus and only shows its segment enables.
   sld_core #(.NUM_SEG(16)) dut16_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
      .sleep_in(sleep_in), .crystal_timer_oscillator(xtal), .low_frequency_internal_oscillator(lfo),
      .ladder_mode_b(mode_b), .active_status(), .common_index(), .drive_phase(), .waveform_type(),
      .bias_level(), .segment_enable(seg16), .pixel_row(), .ref_ctl());
   // ************************************************************
   // Helpers.
   // ************************************************************
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         n_fail++;
         end_of_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
      apb(1'b0, a, 8'h00);
      check(rd & {24'h00_0000, m}, {24'h00_0000, e});
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   // Length of one full common step, then the row shown on the current common.
   task automatic step_len();
      logic [1:0] c;
      int         i;
      c = common_index;
      i = 0;
      while (common_index === c && i < 5000) begin
         @(posedge pclk);
         i++;
      end
      c = common_index;
      n = 0;
      while (common_index === c && n < 5000) begin
         @(posedge pclk);
         n++;
         if (common_index > mx) mx = common_index;
      end
      if (i >= 5000 || n >= 5000) begin
         n_fail++;
         end_of_test();
      end
      repeat (2) @(posedge pclk);
      i = 3 * common_index;
      check({8'h00, pixel_row}, {8'h00, pix[i+2], pix[i+1], pix[i]});
      check({8'h00, panel_u.glass[common_index]}, {8'h00, pix[i+2], pix[i+1], pix[i]});
      if (common_index > mx) mx = common_index;
   endtask
   // ************************************************************
   // Main sequence.
   // ************************************************************
   initial begin
      seed = 32'h056d;
      n_fail = 0;
      total_checks = 0;
      {presetn, psel, penable, pwrite, paddr, pwdata, sleep_in} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rchk(SLD_OFF_CONTROL, 8'h03);
      rchk(SLD_OFF_PHASE, 8'h13);
      rchk(SLD_OFF_REFCTL, 8'h00);
      done("reset");
      apb(1'b1, SLD_OFF_CONTROL, 8'h3F);
      rchk(SLD_OFF_CONTROL, 8'h0F);
      apb(1'b1, SLD_OFF_PHASE, 8'hFF);
      rchk(SLD_OFF_PHASE, 8'hDF);
      apb(1'b1, SLD_OFF_REFCTL, 8'hFF);
      rchk(SLD_OFF_REFCTL, 8'hEE);
      check({ref_ctl.ref_enable, ref_ctl.ref_from_fvr, ref_ctl.bias_pin_connect}, 5'h1F);
      // The buffer follows the ladder mode only after the two-stage synchroniser.
      for (int k = 0; k < 2; k++) begin
         @(posedge lfo);
         repeat (4) @(posedge pclk);
         check(ref_ctl.fvr_buffer_on, !mode_b);
      end
      apb(1'b1, SLD_OFF_REFCTL, 8'h8A);
      @(posedge pclk);
      check(ref_ctl, 7'h55);
      apb(1'b1, SLD_OFF_REFCTL, 8'h4A);
      @(posedge pclk);
      check(ref_ctl, 7'h05);
      apb(1'b1, 8'h0C, 8'h55);
      check(er, 1'b1);
      apb(1'b0, 8'h50, 8'h00);
      check(er, 1'b1);
      done("access");
      for (int i = 0; i < 3; i++) begin
         v = 8'(xs());
         seg[8*i +: 8] = v;
         apb(1'b1, SLD_OFF_SEGEN0 + 8'(4*i), v);
         rchk(SLD_OFF_SEGEN0 + 8'(4*i), v);
      end
      check(segment_enable, seg);
      check(seg16, seg & 24'h00_7FFF);
      for (int i = 0; i < 12; i++) begin
         pix[i] = 8'(xs());
         apb(1'b1, SLD_OFF_PIXEL0 + 8'(4*i), pix[i]);
         rchk(SLD_OFF_PIXEL0 + 8'(4*i), pix[i]);
      end
      done("maps");
      // Software keeps the bias bit clear for static and four-common drive.
      for (int m = 0; m < 4; m++) begin
         for (int b = 0; b < 2; b++) begin
            if (b == 0 || m == 1 || m == 2) begin
               apb(1'b1, SLD_OFF_CONTROL, 8'(m));
               apb(1'b1, SLD_OFF_PHASE, 8'(b << 6));
               @(posedge pclk);
               v = (m == 0) ? 8'(SLD_BIAS_STATIC) : (b == 1) ? 8'(SLD_BIAS_HALF) : 8'(SLD_BIAS_THIRD);
               check(bias_level, v);
            end
         end
      end
      done("bias");
      apb(1'b1, SLD_OFF_CONTROL, 8'h8B);
      repeat (2) @(posedge pclk);
      check({active_status, ref_ctl.ladder_on}, 2'b11);
      rchk(SLD_OFF_PHASE, 8'h20, 8'h20);
      apb(1'b1, SLD_OFF_CONTROL, 8'hCB);
      sleep_in <= 1'b1;
      repeat (5) @(posedge pclk);
      check({active_status, ref_ctl.ladder_on}, 2'b00);
      apb(1'b1, SLD_OFF_CONTROL, 8'h8B);
      repeat (5) @(posedge pclk);
      check(active_status, 1'b1);
      sleep_in <= 1'b0;
      done("sleep");
      for (int s = 0; s < 4; s++) begin
         p = (s == 0) ? 0 : int'(xs() % 16);
         v = 8'(xs() & 32'h0000_0080) | 8'(p);
         apb(1'b1, SLD_OFF_PHASE, v);
         apb(1'b1, SLD_OFF_CONTROL, 8'h83 | 8'(s << 2));
         check(waveform_type, v[7]);
         step_len();
         check(n, (p + 1) * per[s] * (v[7] ? 1 : 2));
      end
      done("clocks");
      apb(1'b1, SLD_OFF_PHASE, 8'h80);
      for (int m = 1; m < 4; m++) begin
         // Switch off at four commons first, so the scan restarts at common 0 before the count shrinks.
         apb(1'b1, SLD_OFF_CONTROL, 8'h0B);
         apb(1'b1, SLD_OFF_CONTROL, 8'h88 | 8'(m));
         mx = 0;
         repeat (8) step_len();
         check(mx, m);
      end
      done("commons");
      apb(1'b1, SLD_OFF_CONTROL, 8'h8B);
      // A write every seven cycles against a step every ten is bound to meet a refused cycle.
      for (int k = 0; k < 12; k++) begin
         v = 8'(xs());
         apb(1'b1, SLD_OFF_PIXEL0, v);
         apb(1'b0, SLD_OFF_CONTROL, 8'h00);
         if (rd[SLD_CTL_WRITE_ERROR_FLAG]) break;
         pix[0] = v;
         @(posedge pclk);
      end
      rchk(SLD_OFF_PIXEL0, pix[0]);
      rchk(SLD_OFF_CONTROL, 8'hAB);
      apb(1'b1, SLD_OFF_CONTROL, 8'hAB);
      rchk(SLD_OFF_CONTROL, 8'hAB);
      apb(1'b1, SLD_OFF_CONTROL, 8'h8B);
      rchk(SLD_OFF_CONTROL, 8'h8B);
      done("error");
      apb(1'b1, SLD_OFF_CONTROL, 8'h0B);
      repeat (3) @(posedge pclk);
      check({active_status, ref_ctl.ladder_on, drive_phase, pixel_row}, 27'h000_0000);
      rchk(SLD_OFF_PHASE, 8'h00, 8'h20);
      done("disable");
      end_of_test();
   end
endmodule
`default_nettype wire
